// ==== dv/dmc_conv_model.sv ====
// Purpose: behavioural converter datapath facing the mode/status block
// Assumes: one done pulse per finished conversion or calibration
// Notes: dly_i picks a prompt or slow answer; fail_i forces a calibration fault
`timescale 1ns/1ps
`default_nettype none
module dmc_conv_model (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire dmc_pkg::dmc_conv_ctl_s ctl_i,
  input wire logic restart_i,
  input wire logic [7:0] dly_i,
  input wire logic [15:0] data_i,
  input wire logic fail_i,
  output var dmc_pkg::dmc_conv_res_s res_o
);
  import dmc_pkg::*;
  logic [7:0] cnt_r;
  // filter held in reset unless enabled, out of hold_reset, and running or calibrating
  wire busy = ctl_i.enable && !ctl_i.hold_reset && (ctl_i.run || ctl_i.calibrate);
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 8'h00;
      res_o <= '0;
    end else begin
      res_o.done <= 1'b0;
      if (restart_i || !busy) begin
        cnt_r <= 8'h00;
      end else if (cnt_r >= dly_i) begin
        cnt_r <= 8'h00;
        // system input assumed applied by the bench before the request
        res_o <= '{1'b1, data_i, fail_i};
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// ==== dv/dmc_mode_status_chk.sv ====
// Purpose: port-level checks of the mode/status block
// Assumes: single clock domain, async reset high
// Notes: attached by bind from the bench top
`timescale 1ns/1ps
`default_nettype none
module dmc_mode_status_chk (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire dmc_pkg::dmc_conv_ctl_s prim_ctl_o,
  input wire dmc_pkg::dmc_conv_ctl_s aux_ctl_o,
  input wire logic conv_reset_both_o,
  input wire logic aux_reset_only_o,
  input wire logic [7:0] decimation_factor_o
);
  import dmc_pkg::*;
  wire mw = sfr_wr_i && sfr_addr_i == DMC_MODE_ADDR;
  wire [5:0] mv = sfr_wdata_i[5:0];
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////
  a_mode_resets: assert property (mw && mv[5] && mv[2:0] != 3'h0 |=> conv_reset_both_o)
    else $error("mode write gave no reset pulse");
  a_prim_off: assert property (mw && !mv[5] |=> !prim_ctl_o.enable && !prim_ctl_o.run)
    else $error("primary not powered down");
  a_aux_off: assert property (mw && !mv[4] |=> !aux_ctl_o.enable && !aux_ctl_o.run)
    else $error("auxiliary not powered down");
  a_idle_hold: assert property (mw && mv == 6'h21 |=> prim_ctl_o.hold_reset && !prim_ctl_o.run)
    else $error("idle does not hold reset");
  a_single_run: assert property (mw && mv == 6'h22 |=> prim_ctl_o.run && !prim_ctl_o.calibrate)
    else $error("single mode not running");
  a_zero_short: assert property (mw && mv == 6'h24 |=> prim_ctl_o.calibrate && prim_ctl_o.in_sel == DMC_IN_SHORT)
    else $error("zero-scale input not shorted");
  a_full_ref: assert property (mw && mv == 6'h25 |=> prim_ctl_o.cal_full && prim_ctl_o.in_sel == DMC_IN_REF)
    else $error("full-scale input not reference");
  a_sys_chan: assert property (mw && mv[5] && mv[2:1] == 2'h3 |=> prim_ctl_o.calibrate && prim_ctl_o.in_sel == DMC_IN_CHAN)
    else $error("system calibration not on channel pins");
  a_dec_follow: assert property (sfr_wr_i && sfr_addr_i == DMC_DEC_ADDR |=> decimation_factor_o == $past(sfr_wdata_i))
    else $error("decimation output wrong");
  a_rdata_hold: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
    else $error("read data moved without a read");
  a_aux_cfg_reset: assert property (sfr_wr_i && sfr_addr_i == DMC_ACFG_ADDR |=> aux_reset_only_o && !conv_reset_both_o)
    else $error("auxiliary config write gave no auxiliary-only reset");
  a_prim_cfg_reset: assert property (sfr_wr_i && sfr_addr_i == DMC_PCFG_ADDR |=> conv_reset_both_o && !aux_reset_only_o)
    else $error("primary config write gave no reset of both");
endmodule
`default_nettype wire

// ==== dv/test_dmc_mode_status.sv ====
// Purpose: self-checking bench for the mode/status block
// Assumes: reads checked from a queue of expected bytes
// Notes: conversion data kept off the clamp codes unless clamping is meant
`timescale 1ns/1ps
`default_nettype none
module test_dmc_mode_status;
  import dmc_pkg::*;
  logic core_clk_i, rst_i, wr, rd_s, refm, pfail, rboth, raux;
  logic [7:0] addr, wdata, rdata, pdly, dec;
  logic [15:0] pdat, adat, d, off;
  dmc_conv_res_s pres, ares;
  dmc_conv_ctl_s pctl, actl;
  logic [7:0] exp_q[$];
  int fail_count, tests_run, i;
  integer seed;
  dmc_mode_status dmc_mode_status_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .sfr_addr_i(addr),
    .sfr_wdata_i(wdata), .sfr_wr_i(wr), .sfr_rd_i(rd_s), .sfr_rdata_o(rdata), .reference_missing_i(refm),
    .prim_res_i(pres), .aux_res_i(ares), .prim_ctl_o(pctl), .aux_ctl_o(actl), .conv_reset_both_o(rboth),
    .aux_reset_only_o(raux), .decimation_factor_o(dec));
  dmc_conv_model dmc_conv_model_inst (.core_clk_i(core_clk_i), .rst_i(rst_i), .ctl_i(pctl), .restart_i(rboth),
    .dly_i(pdly), .data_i(pdat), .fail_i(pfail), .res_o(pres));
  dmc_conv_model dmc_conv_model_inst_aux (.core_clk_i(core_clk_i), .rst_i(rst_i), .ctl_i(actl),
    .restart_i(rboth | raux), .dly_i(pdly), .data_i(adat), .fail_i(1'b0), .res_o(ares));
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] e);
    tests_run++;
    if (seen !== e) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, e);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk_i);
    #1;
    {wr, rd_s, addr, wdata} = {w, !w, a, v};
    @(posedge core_clk_i);
    #1;
    {wr, rd_s} = 2'b00;
  endtask
  task automatic wm(input logic [7:0] a, input logic [7:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 8'h00);
  endtask
  task automatic rd16(input logic [7:0] ah, input logic [7:0] al, input logic [15:0] e);
    rd(ah, e[15:8]);
    rd(al, e[7:0]);
  endtask
  // done is read before the edge's updates land, as the block samples it
  task automatic wdone(input logic aux);
    int n;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (!(aux ? ares.done : pres.done) && n < 300);
    // step off the edge before the caller drives anything
    #1;
    if (n >= 300) fail_count++;
  endtask
  task automatic conv(input logic [7:0] m, input logic [15:0] v, input logic aux);
    if (aux) adat = v;
    else pdat = v;
    wm(DMC_MODE_ADDR, m);
    wdone(aux);
  endtask
  function automatic logic [15:0] rnd();
    logic [31:0] r;
    r = $random(seed);
    return {1'b0, r[14:1], 1'b1};
  endfunction
  ////////////////////////////////////////////////////////////
  always @(posedge core_clk_i) begin
    if (rd_s) begin
      #2;
      chk(rdata, exp_q.pop_front());
    end
  end
  initial begin
    #300000;
    fail_count++;
    close_out();
  end
  initial begin
    seed = 32'h3CCB6FC8;
    {wr, rd_s, refm, pfail} = 4'h0;
    {addr, wdata, pdly, pdat, adat} = {8'h00, 8'h00, 8'h05, 16'h0000, 16'h0000};
    rst_i = 1'b1;
    repeat (10) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    rd(DMC_STAT_ADDR, DMC_STAT_RST);
    rd(DMC_MODE_ADDR, DMC_MODE_RST);
    rd(DMC_DEC_ADDR, DMC_DEC_RST);
    wm(8'h80, 8'h5A);
    rd(8'h80, 8'h00);
    wm(DMC_MODE_ADDR, 8'hC9);
    rd(DMC_MODE_ADDR, 8'h01);
    wm(DMC_MODE_ADDR, 8'h21);
    wm(DMC_STAT_ADDR, 8'hFF);
    rd(DMC_STAT_ADDR, 8'hC0);
    wm(DMC_STAT_ADDR, 8'h00);
    rd(DMC_STAT_ADDR, 8'h00);
    d = rnd();
    conv(8'h22, d, 1'b0);
    rd(DMC_STAT_ADDR, 8'h80);
    rd(DMC_MODE_ADDR, 8'h20);
    rd16(DMC_PRES_H_ADDR, DMC_PRES_L_ADDR, d);
    // a set ready flag must freeze the result until cleared
    conv(8'h23, d, 1'b0);
    pdat = rnd();
    wdone(1'b0);
    rd16(DMC_PRES_H_ADDR, DMC_PRES_L_ADDR, d);
    wm(DMC_STAT_ADDR, 8'h00);
    wdone(1'b0);
    rd16(DMC_PRES_H_ADDR, DMC_PRES_L_ADDR, pdat);
    wm(DMC_MODE_ADDR, 8'h00);
    conv(8'h22, 16'hFFFF, 1'b0);
    rd(DMC_STAT_ADDR, 8'h88);
    conv(8'h22, 16'h0000, 1'b0);
    rd(DMC_STAT_ADDR, 8'h88);
    conv(8'h22, d, 1'b0);
    rd(DMC_STAT_ADDR, 8'h80);
    wm(DMC_PCFG_ADDR, 8'h47);
    {refm, pdly} = {1'b1, 8'h1E};
    pdat = d;
    wm(DMC_MODE_ADDR, 8'h23);
    rd(DMC_STAT_ADDR, 8'h10);
    wdone(1'b0);
    rd16(DMC_PRES_H_ADDR, DMC_PRES_L_ADDR, DMC_ALL_ONES);
    wm(DMC_MODE_ADDR, 8'h00);
    {refm, pdly} = {1'b0, 8'h05};
    wm(DMC_PCFG_ADDR, DMC_PCFG_RST);
    for (i = 4; i < 8; i++) begin
      d = rnd();
      if (!i[0]) off = d;
      conv(8'h20 | i[7:0], d, 1'b0);
      rd(DMC_STAT_ADDR, 8'hA0);
      rd(DMC_MODE_ADDR, 8'h20);
      rd(i[0] ? DMC_PGN_H_ADDR : DMC_POFF_H_ADDR, d[15:8]);
    end
    pfail = 1'b1;
    conv(8'h24, rnd(), 1'b0);
    rd(DMC_STAT_ADDR, 8'hA8);
    rd(DMC_POFF_H_ADDR, off[15:8]);
    pfail = 1'b0;
    wm(DMC_ACFG_ADDR, 8'h20);
    conv(8'h14, rnd(), 1'b1);
    rd(DMC_STAT_ADDR, 8'h64);
    rd(DMC_AOFF_H_ADDR, DMC_OFF_RST[15:8]);
    wm(DMC_ACFG_ADDR, 8'h00);
    d = rnd();
    conv(8'h12, d, 1'b1);
    rd(DMC_STAT_ADDR, 8'h40);
    rd16(DMC_ARES_H_ADDR, DMC_ARES_L_ADDR, d);
    conv(8'h12, 16'h0000, 1'b1);
    rd(DMC_STAT_ADDR, 8'h44);
    d = rnd();
    conv(8'h15, d, 1'b1);
    rd(DMC_STAT_ADDR, 8'h60);
    rd16(DMC_AGN_H_ADDR, DMC_AGN_L_ADDR, d);
    d = rnd();
    wm(DMC_DEC_ADDR, d[7:0]);
    rd(DMC_DEC_ADDR, d[7:0]);
    repeat (3) @(posedge core_clk_i);
    close_out();
  end
endmodule
bind dmc_mode_status dmc_mode_status_chk dmc_mode_status_chk_inst (.core_clk_i, .rst_i, .sfr_addr_i,
  .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .prim_ctl_o, .aux_ctl_o, .conv_reset_both_o,
  .aux_reset_only_o, .decimation_factor_o);
`default_nettype wire

// ==== hdl/dmc_mode_status.sv ====
// Purpose: mode, status, result and coefficient registers for two sigma-delta converters
// Assumes: SFR-style byte port, writes and reads synchronous to core_clk_i
// Notes: datapath reports done pulses with data; this block gates and stores them
`timescale 1ns/1ps
`default_nettype none
module dmc_mode_status (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic reference_missing_i,
  input wire dmc_pkg::dmc_conv_res_s prim_res_i,
  input wire dmc_pkg::dmc_conv_res_s aux_res_i,
  output var dmc_pkg::dmc_conv_ctl_s prim_ctl_o,
  output var dmc_pkg::dmc_conv_ctl_s aux_ctl_o,
  output logic conv_reset_both_o,
  output logic aux_reset_only_o,
  output logic [7:0] decimation_factor_o
);
  import dmc_pkg::*;

  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic [7:0] pcfg_r;
  logic [7:0] acfg_r;
  logic [7:0] dec_r;
  logic [15:0] pres_r;
  logic [15:0] ares_r;
  logic [15:0] poff_r;
  logic [15:0] aoff_r;
  logic [15:0] pgain_r;
  logic [15:0] again_r;
  logic [7:0] rdata_r;
  dmc_conv_ctl_s pctl_r;
  dmc_conv_ctl_s actl_r;
  logic rst_both_r;
  logic rst_aux_r;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  function automatic dmc_conv_ctl_s decode_ctl(input logic en, input logic [2:0] md);
    dmc_conv_ctl_s c;
    c.enable = en && (md != DMC_MD_PDOWN);
    c.hold_reset = en && (md == DMC_MD_IDLE);
    c.run = en && (md == DMC_MD_SINGLE || md == DMC_MD_CONT);
    c.calibrate = en && md[2];
    c.cal_full = en && md[2] && md[0];
    case (md)
      DMC_MD_IZS: begin
        c.in_sel = DMC_IN_SHORT;
      end
      DMC_MD_IFS: begin
        // internal or external source follows the datapath's own select bit
        c.in_sel = DMC_IN_REF;
      end
      default: begin
        c.in_sel = DMC_IN_CHAN;
      end
    endcase
    decode_ctl = c;
  endfunction

  function automatic logic is_clamped(input logic [15:0] d);
    is_clamped = (d == DMC_ALL_ONES) || (d == DMC_ALL_ZEROS);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // write decode and mode tracking
  wire wr_mode = sfr_wr_i && hit(sfr_addr_i, DMC_MODE_ADDR);
  wire wr_stat = sfr_wr_i && hit(sfr_addr_i, DMC_STAT_ADDR);
  wire wr_pcfg = sfr_wr_i && hit(sfr_addr_i, DMC_PCFG_ADDR);
  wire wr_acfg = sfr_wr_i && hit(sfr_addr_i, DMC_ACFG_ADDR);
  wire wr_dec = sfr_wr_i && hit(sfr_addr_i, DMC_DEC_ADDR);
  wire [7:0] wmode = sfr_wdata_i & DMC_MODE_MASK;
  wire [2:0] md = mode_r[2:0];
  wire [2:0] wmd = wmode[2:0];
  wire p_en = mode_r[DMC_PEN_BIT];
  wire a_en = mode_r[DMC_AEN_BIT];
  wire md_start = wr_mode && (wmd != DMC_MD_PDOWN);
  // unchanged mode with only the auxiliary enabled does not disturb the primary
  wire aux_only = wr_mode && (wmd == md) && !wmode[DMC_PEN_BIT] && wmode[DMC_AEN_BIT];
  wire reset_both = wr_mode && !aux_only;
  wire reset_aux = aux_only || wr_acfg || (wr_mode && wmode[DMC_AEN_BIT] && !a_en);
  // a converter counts as active only when enabled and out of power-down
  wire p_live = p_en && (md != DMC_MD_PDOWN);
  wire a_live = a_en && (md != DMC_MD_PDOWN);
  wire active = p_live || a_live;
  wire cal_mode = md[2];
  wire single_mode = (md == DMC_MD_SINGLE);

  ////////////////////////////////////////////////////////////////////////
  // completion gating
  wire primary_ready = status_r[DMC_PRIMARY_READY_BIT];
  wire auxiliary_ready = status_r[DMC_AUXILIARY_READY_BIT];
  // a start write in the same cycle discards the stale completion
  wire p_done = prim_res_i.done && p_live && !primary_ready && !wr_mode;
  wire a_done = aux_res_i.done && a_live && !auxiliary_ready && !wr_mode;
  wire p_xref_bad = pcfg_r[DMC_XREF_BIT] && status_r[DMC_NOREF_BIT];
  wire a_xref_bad = acfg_r[DMC_XREF_BIT] && status_r[DMC_NOREF_BIT];
  wire [15:0] p_data = p_xref_bad ? DMC_ALL_ONES : prim_res_i.data;
  wire [15:0] a_data = a_xref_bad ? DMC_ALL_ONES : aux_res_i.data;
  wire a_temp = (acfg_r[5:4] == DMC_TEMP_SEL);
  wire p_cal_ok = cal_mode && p_done && !prim_res_i.cal_fail;
  wire a_cal_ok = cal_mode && a_done && !aux_res_i.cal_fail && !a_temp;
  wire p_conv = !cal_mode && p_done;
  wire a_conv = !cal_mode && a_done;
  wire p_err = p_conv ? is_clamped(p_data) : (p_done && !p_cal_ok);
  wire a_err = a_conv ? is_clamped(a_data) : (a_done && !a_cal_ok);
  // all enabled converters finished; single and calibration then drop to power-down
  wire p_fin = !p_en || p_done || primary_ready;
  wire a_fin = !a_en || a_done || auxiliary_ready;
  wire op_end = (single_mode || cal_mode) && active && (p_done || a_done) && p_fin && a_fin;

  ////////////////////////////////////////////////////////////////////////
  // next-state for mode and status
  always_comb begin
    mode_nxt = mode_r;
    if (wr_mode) begin
      mode_nxt = wmode;
    end else if (op_end) begin
      mode_nxt = {mode_r[7:3], DMC_MD_PDOWN};
    end
  end

  always_comb begin
    status_nxt = status_r;
    if (wr_stat) begin
      status_nxt[DMC_PRIMARY_READY_BIT] = sfr_wdata_i[DMC_PRIMARY_READY_BIT];
      status_nxt[DMC_AUXILIARY_READY_BIT] = sfr_wdata_i[DMC_AUXILIARY_READY_BIT];
    end
    if (md_start) begin
      status_nxt[DMC_PRIMARY_READY_BIT] = 1'b0;
      status_nxt[DMC_AUXILIARY_READY_BIT] = 1'b0;
      status_nxt[DMC_CAL_BIT] = 1'b0;
      status_nxt[DMC_PRIMARY_ERROR_BIT] = 1'b0;
      status_nxt[DMC_AUXILIARY_ERROR_BIT] = 1'b0;
    end
    // hardware sets win over software clears
    if (p_done) begin
      status_nxt[DMC_PRIMARY_READY_BIT] = 1'b1;
    end
    if (a_done) begin
      status_nxt[DMC_AUXILIARY_READY_BIT] = 1'b1;
    end
    if (p_err) begin
      status_nxt[DMC_PRIMARY_ERROR_BIT] = 1'b1;
    end
    if (a_err) begin
      status_nxt[DMC_AUXILIARY_ERROR_BIT] = 1'b1;
    end
    if (op_end && cal_mode) begin
      status_nxt[DMC_CAL_BIT] = 1'b1;
    end
    status_nxt[DMC_NOREF_BIT] = active && reference_missing_i;
    status_nxt = status_nxt & DMC_STAT_MASK;
  end

  ////////////////////////////////////////////////////////////////////////
  // register storage
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= DMC_MODE_RST;
      status_r <= DMC_STAT_RST;
    end else begin
      mode_r <= mode_nxt;
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pcfg_r <= DMC_PCFG_RST;
      acfg_r <= DMC_ACFG_RST;
      dec_r <= DMC_DEC_RST;
    end else begin
      if (wr_pcfg) begin
        pcfg_r <= sfr_wdata_i;
      end
      if (wr_acfg) begin
        acfg_r <= sfr_wdata_i;
      end
      if (wr_dec) begin
        dec_r <= sfr_wdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pres_r <= DMC_ALL_ZEROS;
      ares_r <= DMC_ALL_ZEROS;
    end else begin
      if (p_conv) begin
        pres_r <= p_data;
      end
      if (a_conv) begin
        ares_r <= a_data;
      end
    end
  end

  // coefficient bytes are software writable; calibration writes them on success
  // coefficients take the raw datapath word; all-ones forcing is for results only
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      poff_r <= DMC_OFF_RST;
      pgain_r <= DMC_GAIN_RST;
    end else if (p_cal_ok) begin
      if (md[0]) begin
        pgain_r <= prim_res_i.data;
      end else begin
        poff_r <= prim_res_i.data;
      end
    end else if (sfr_wr_i) begin
      poff_r <= {hit(sfr_addr_i, DMC_POFF_H_ADDR) ? sfr_wdata_i : poff_r[15:8],
                 hit(sfr_addr_i, DMC_POFF_L_ADDR) ? sfr_wdata_i : poff_r[7:0]};
      pgain_r <= {hit(sfr_addr_i, DMC_PGN_H_ADDR) ? sfr_wdata_i : pgain_r[15:8],
                  hit(sfr_addr_i, DMC_PGN_L_ADDR) ? sfr_wdata_i : pgain_r[7:0]};
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      aoff_r <= DMC_OFF_RST;
      again_r <= DMC_GAIN_RST;
    end else if (a_cal_ok) begin
      if (md[0]) begin
        again_r <= aux_res_i.data;
      end else begin
        aoff_r <= aux_res_i.data;
      end
    end else if (sfr_wr_i) begin
      aoff_r <= {hit(sfr_addr_i, DMC_AOFF_H_ADDR) ? sfr_wdata_i : aoff_r[15:8],
                 hit(sfr_addr_i, DMC_AOFF_L_ADDR) ? sfr_wdata_i : aoff_r[7:0]};
      again_r <= {hit(sfr_addr_i, DMC_AGN_H_ADDR) ? sfr_wdata_i : again_r[15:8],
                  hit(sfr_addr_i, DMC_AGN_L_ADDR) ? sfr_wdata_i : again_r[7:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux, registered; unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (sfr_addr_i)
      DMC_MODE_ADDR: rd_mux = mode_r & DMC_MODE_MASK;
      DMC_STAT_ADDR: rd_mux = status_r & DMC_STAT_MASK;
      DMC_PCFG_ADDR: rd_mux = pcfg_r;
      DMC_ACFG_ADDR: rd_mux = acfg_r;
      DMC_DEC_ADDR: rd_mux = dec_r;
      DMC_PRES_H_ADDR: rd_mux = pres_r[15:8];
      DMC_PRES_L_ADDR: rd_mux = pres_r[7:0];
      DMC_ARES_H_ADDR: rd_mux = ares_r[15:8];
      DMC_ARES_L_ADDR: rd_mux = ares_r[7:0];
      DMC_POFF_H_ADDR: rd_mux = poff_r[15:8];
      DMC_POFF_L_ADDR: rd_mux = poff_r[7:0];
      DMC_AOFF_H_ADDR: rd_mux = aoff_r[15:8];
      DMC_AOFF_L_ADDR: rd_mux = aoff_r[7:0];
      DMC_PGN_H_ADDR: rd_mux = pgain_r[15:8];
      DMC_PGN_L_ADDR: rd_mux = pgain_r[7:0];
      DMC_AGN_H_ADDR: rd_mux = again_r[15:8];
      DMC_AGN_L_ADDR: rd_mux = again_r[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // converter control outputs, from flops
  wire dmc_conv_ctl_s pctl_nxt = decode_ctl(mode_nxt[DMC_PEN_BIT], mode_nxt[2:0]);
  wire dmc_conv_ctl_s actl_nxt = decode_ctl(mode_nxt[DMC_AEN_BIT], mode_nxt[2:0]);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pctl_r <= '0;
      actl_r <= '0;
    end else begin
      pctl_r <= pctl_nxt;
      actl_r <= actl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data holds until the next read strobe
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
    end else if (sfr_rd_i) begin
      rdata_r <= rd_mux;
    end
  end

  // one-cycle pulses; a primary change restarts both so the auxiliary stays in step
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rst_both_r <= 1'b0;
      rst_aux_r <= 1'b0;
    end else begin
      rst_both_r <= reset_both || wr_pcfg;
      rst_aux_r <= reset_aux && !reset_both;
    end
  end

  assign sfr_rdata_o = rdata_r;
  assign prim_ctl_o = pctl_r;
  assign aux_ctl_o = actl_r;
  assign conv_reset_both_o = rst_both_r;
  assign aux_reset_only_o = rst_aux_r;
  assign decimation_factor_o = dec_r;
endmodule
`default_nettype wire

// ==== hdl/dmc_pkg.sv ====
// Purpose: constants and carrier types for the dual converter mode/status block
// Assumes: 8-bit special-function-register access, byte-wide data
// Notes: offsets are the register addresses in the SFR space
package dmc_pkg;
  localparam logic [7:0] DMC_MODE_ADDR = 8'hD1;
  localparam logic [7:0] DMC_STAT_ADDR = 8'hD8;
  localparam logic [7:0] DMC_PCFG_ADDR = 8'hD2;
  localparam logic [7:0] DMC_ACFG_ADDR = 8'hD3;
  localparam logic [7:0] DMC_DEC_ADDR = 8'hD4;
  localparam logic [7:0] DMC_PRES_H_ADDR = 8'hDA;
  localparam logic [7:0] DMC_PRES_L_ADDR = 8'hD9;
  localparam logic [7:0] DMC_ARES_H_ADDR = 8'hDC;
  localparam logic [7:0] DMC_ARES_L_ADDR = 8'hDB;
  localparam logic [7:0] DMC_POFF_H_ADDR = 8'hE2;
  localparam logic [7:0] DMC_POFF_L_ADDR = 8'hE1;
  localparam logic [7:0] DMC_AOFF_H_ADDR = 8'hE4;
  localparam logic [7:0] DMC_AOFF_L_ADDR = 8'hE3;
  localparam logic [7:0] DMC_PGN_H_ADDR = 8'hEA;
  localparam logic [7:0] DMC_PGN_L_ADDR = 8'hE9;
  localparam logic [7:0] DMC_AGN_H_ADDR = 8'hEC;
  localparam logic [7:0] DMC_AGN_L_ADDR = 8'hEB;
  localparam logic [7:0] DMC_MODE_RST = 8'h00;
  localparam logic [7:0] DMC_STAT_RST = 8'h00;
  localparam logic [7:0] DMC_PCFG_RST = 8'h07;
  localparam logic [7:0] DMC_ACFG_RST = 8'h00;
  localparam logic [7:0] DMC_DEC_RST = 8'h45;
  localparam logic [15:0] DMC_OFF_RST = 16'h8000;
  localparam logic [15:0] DMC_GAIN_RST = 16'h5555;
  localparam logic [7:0] DMC_MODE_MASK = 8'h37;
  localparam logic [7:0] DMC_STAT_MASK = 8'hFC;
  localparam int DMC_PEN_BIT = 5;
  localparam int DMC_AEN_BIT = 4;
  localparam int DMC_PRIMARY_READY_BIT = 7;
  localparam int DMC_AUXILIARY_READY_BIT = 6;
  localparam int DMC_CAL_BIT = 5;
  localparam int DMC_NOREF_BIT = 4;
  localparam int DMC_PRIMARY_ERROR_BIT = 3;
  localparam int DMC_AUXILIARY_ERROR_BIT = 2;
  localparam int DMC_XREF_BIT = 6;
  localparam logic [1:0] DMC_TEMP_SEL = 2'h2;
  localparam logic [2:0] DMC_MD_PDOWN = 3'h0;
  localparam logic [2:0] DMC_MD_IDLE = 3'h1;
  localparam logic [2:0] DMC_MD_SINGLE = 3'h2;
  localparam logic [2:0] DMC_MD_CONT = 3'h3;
  localparam logic [2:0] DMC_MD_IZS = 3'h4;
  localparam logic [2:0] DMC_MD_IFS = 3'h5;
  localparam logic [2:0] DMC_MD_SZS = 3'h6;
  localparam logic [2:0] DMC_MD_SFS = 3'h7;
  localparam logic [15:0] DMC_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] DMC_ALL_ZEROS = 16'h0000;

  typedef enum logic [1:0] {
    DMC_IN_CHAN = 2'h0,
    DMC_IN_SHORT = 2'h1,
    DMC_IN_REF = 2'h2
  } dmc_insel_e;

  typedef struct packed {
    logic enable;
    logic hold_reset;
    logic run;
    logic calibrate;
    logic cal_full;
    dmc_insel_e in_sel;
  } dmc_conv_ctl_s;

  typedef struct packed {
    logic done;
    logic [15:0] data;
    logic cal_fail;
  } dmc_conv_res_s;
endpackage
